/* pkg/tor_map.svh */
// register offsets, field positions, reset values and fixed-point constants of the
// thermal overload replica; included by the package user files only
`ifndef TOR_MAP_SVH
`define TOR_MAP_SVH

`define TOR_OFF_CTRL 12'h000
`define TOR_OFF_KINV 12'h004
`define TOR_OFF_TAU 12'h008
`define TOR_OFF_KSTOP 12'h00c
`define TOR_OFF_ALARM_PCT 12'h010
`define TOR_OFF_I_ALARM 12'h014
`define TOR_OFF_I_MIN 12'h018
`define TOR_OFF_I_FREEZE 12'h01c
`define TOR_OFF_T_EMER 12'h020
`define TOR_OFF_AMB_SCALE 12'h024
`define TOR_OFF_TICK_DIV 12'h028
`define TOR_OFF_STATUS 12'h02c
`define TOR_OFF_THETA 12'h030

`define TOR_CTRL_MODE_LO 0
`define TOR_CTRL_MODE_HI 1
`define TOR_CTRL_AMB_EN 2

`define TOR_ST_ALARM 0
`define TOR_ST_I_ALARM 1
`define TOR_ST_TRIP 2
`define TOR_ST_AMB_ERR 3
`define TOR_ST_STANDSTILL 4
`define TOR_ST_FROZEN 5
`define TOR_ST_EMER 6
`define TOR_ST_BLOCKED 7

// replica value: 1.0 (trip overtemperature) = 2^16
`define TOR_THETA_ONE 32'h0001_0000
`define TOR_AMB_DEFAULT 16'h0028
`define TOR_PCT_FULL 32'h0000_0064
`define TOR_RST_KINV 32'h0000_0100
`define TOR_RST_TAU 32'h0001_0000
`define TOR_RST_KSTOP 32'h0000_0500
`define TOR_RST_ALARM_PCT 32'h0000_005a
`define TOR_RST_I_ALARM 32'h0000_ffff
`define TOR_RST_I_MIN 32'h0000_0010
`define TOR_RST_I_FREEZE 32'h0000_ffff
`define TOR_RST_T_EMER 32'h0000_0064
`define TOR_RST_TICK_DIV 32'h0000_00f9
`define TOR_KSTOP_FRAC 8

`endif

/* pkg/tor_pkg.sv */
// types shared by the thermal overload replica files
package tor_pkg;

    typedef enum logic [1:0] {
        TOR_MODE_OFF = 2'b00,
        TOR_MODE_ON = 2'b01,
        TOR_MODE_ALARM_ONLY = 2'b10
    } tor_mode_t;

    typedef struct packed {
        logic [15:0] ia;
        logic [15:0] ib;
        logic [15:0] ic;
    } tor_phase_t;

    typedef struct packed {
        logic thermal_alarm;
        logic current_alarm;
        logic trip;
        logic trip_log;
        logic amb_alarm;
    } tor_out_t;

endpackage : tor_pkg

/* logic/tor_phase_ram.sv */
// three-word store for the per-phase replica values
// assumes one writer and one reader on the same clock; read data is registered
`timescale 1ns/1ps

module tor_phase_ram #(
    parameter int WIDTH = 32
) (
    // clock
    input wire logic aclk,
    // write port
    input wire logic we,
    input wire logic [1:0] waddr,
    input wire logic [WIDTH-1:0] wdata,
    // read port
    input wire logic [1:0] raddr,
    output logic [WIDTH-1:0] rdata
);
    logic [WIDTH-1:0] mem [0:2];

    always_ff @(posedge aclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge aclk) begin
        rdata <= mem[raddr];
    end
endmodule : tor_phase_ram

/* logic/tor_top.sv */
// thermal overload replica with axi4-lite register slave
// assumes phase rms values and binary inputs arrive asynchronously; one clock aclk
`timescale 1ns/1ps
`include "tor_map.svh"

// Behaviour
// - first-order replica per phase from current squared
// - no ambient measured: ambient term zero
// - thermal alarm at alarm level
// - trip at trip level
// - compare largest of three phase values
// - alarm level is percent of trip
// - current alarm independent of replica
// - ambient from first sensor input
// - bad ambient: alarm, use default
// - standstill: time constant times stop factor
// - freeze replica above freeze current
// - memory reset input zeroes replica
// - block input zeroes and suppresses everything
// - emergency start suppresses trip
// - run-on timer extends trip suppression
// - emergency affects trip only
// - alarm-only mode: no trip, no log
// - parameter write resets replica
module tor_top (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // measurements
    input wire tor_pkg::tor_phase_t phase_rms,
    input wire logic [15:0] amb_temp,
    input wire logic amb_valid,
    // binary inputs
    input wire logic thermal_memory_reset_in,
    input wire logic overload_block_in,
    input wire logic emergency_start_in,
    // messages
    output tor_pkg::tor_out_t msg
);
    // registers
    logic [1:0] mode_reg;
    logic amb_en_reg;
    logic [31:0] kinv_reg, tau_reg, kstop_reg, alarm_pct_reg, i_alarm_reg;
    logic [31:0] i_min_reg, i_freeze_reg, t_emer_reg, amb_scale_reg, tick_div_reg;
    logic param_wr;

    // axi write channel
    logic [11:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic aw_held, w_held;
    logic wr_fire;
    logic wr_ok;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign wr_fire = aw_held && w_held && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            awaddr_reg <= 12'h000;
            wdata_reg <= 32'h0000_0000;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                wdata_reg <= s_axi_wdata;
            end else if (wr_fire) begin
                w_held <= 1'b0;
            end
        end
    end

    function automatic logic is_param(input logic [11:0] a);
        case (a)
            `TOR_OFF_CTRL, `TOR_OFF_KINV, `TOR_OFF_TAU, `TOR_OFF_KSTOP,
            `TOR_OFF_ALARM_PCT, `TOR_OFF_I_ALARM, `TOR_OFF_I_MIN,
            `TOR_OFF_I_FREEZE, `TOR_OFF_T_EMER, `TOR_OFF_AMB_SCALE,
            `TOR_OFF_TICK_DIV: is_param = 1'b1;
            default: is_param = 1'b0;
        endcase
    endfunction : is_param

    assign wr_ok = is_param(awaddr_reg);
    assign param_wr = wr_fire && wr_ok;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? 2'b00 : 2'b10;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // parameter store; whole-word writes, byte strobes ignored
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_reg <= tor_pkg::TOR_MODE_ON;
            amb_en_reg <= 1'b0;
            kinv_reg <= `TOR_RST_KINV;
            tau_reg <= `TOR_RST_TAU;
            kstop_reg <= `TOR_RST_KSTOP;
            alarm_pct_reg <= `TOR_RST_ALARM_PCT;
            i_alarm_reg <= `TOR_RST_I_ALARM;
            i_min_reg <= `TOR_RST_I_MIN;
            i_freeze_reg <= `TOR_RST_I_FREEZE;
            t_emer_reg <= `TOR_RST_T_EMER;
            amb_scale_reg <= 32'h0000_0000;
            tick_div_reg <= `TOR_RST_TICK_DIV;
        end else if (param_wr) begin
            case (awaddr_reg)
                `TOR_OFF_CTRL: begin
                    mode_reg <= wdata_reg[`TOR_CTRL_MODE_HI:`TOR_CTRL_MODE_LO];
                    amb_en_reg <= wdata_reg[`TOR_CTRL_AMB_EN];
                end
                `TOR_OFF_KINV: kinv_reg <= wdata_reg;
                `TOR_OFF_TAU: tau_reg <= (wdata_reg == 32'h0) ? 32'h1 : wdata_reg;
                `TOR_OFF_KSTOP: kstop_reg <= wdata_reg;
                `TOR_OFF_ALARM_PCT: alarm_pct_reg <= wdata_reg;
                `TOR_OFF_I_ALARM: i_alarm_reg <= wdata_reg;
                `TOR_OFF_I_MIN: i_min_reg <= wdata_reg;
                `TOR_OFF_I_FREEZE: i_freeze_reg <= wdata_reg;
                `TOR_OFF_T_EMER: t_emer_reg <= wdata_reg;
                `TOR_OFF_AMB_SCALE: amb_scale_reg <= wdata_reg;
                `TOR_OFF_TICK_DIV: tick_div_reg <= wdata_reg;
                default: mode_reg <= mode_reg;
            endcase
        end
    end

    // input synchronisers
    logic [2:0] bin_s1, bin_s2;
    tor_pkg::tor_phase_t ph_s1, ph_s2;
    logic [16:0] amb_s1, amb_s2;

    always_ff @(posedge aclk) begin
        bin_s1 <= {emergency_start_in, overload_block_in, thermal_memory_reset_in};
        bin_s2 <= bin_s1;
        ph_s1 <= phase_rms;
        ph_s2 <= ph_s1;
        amb_s1 <= {amb_valid, amb_temp};
        amb_s2 <= amb_s1;
    end

    logic mem_reset, blocked, emer_in, mode_off;
    assign mem_reset = bin_s2[0];
    assign blocked = bin_s2[1];
    assign emer_in = bin_s2[2];
    assign mode_off = (mode_reg == tor_pkg::TOR_MODE_OFF);

    // processing tick
    logic [31:0] div_cnt;
    logic tick;
    always_ff @(posedge aclk) begin
        if (!aresetn || div_cnt >= tick_div_reg) begin
            div_cnt <= 32'h0;
        end else begin
            div_cnt <= div_cnt + 32'h1;
        end
    end
    assign tick = aresetn && (div_cnt >= tick_div_reg);

    function automatic logic [15:0] imax3(input tor_pkg::tor_phase_t p);
        logic [15:0] m;
        m = (p.ia > p.ib) ? p.ia : p.ib;
        imax3 = (m > p.ic) ? m : p.ic;
    endfunction : imax3

    logic [15:0] i_max;
    logic standstill, frozen;
    assign i_max = imax3(ph_s2);
    assign standstill = ({16'h0, i_max} < i_min_reg);
    assign frozen = ({16'h0, i_max} > i_freeze_reg);

    // ambient term, in replica units
    logic amb_err;
    logic signed [31:0] amb_term;
    assign amb_err = amb_en_reg && !amb_s2[16];
    always_comb begin
        amb_term = 32'sh0;
        if (amb_en_reg && amb_s2[16]) begin
            amb_term = 32'($signed({1'b0, amb_s2[15:0]}) - $signed({1'b0, `TOR_AMB_DEFAULT}))
                * $signed(amb_scale_reg);
        end
    end

    // sequencer over phases on each tick that arrives while it is in ST_IDLE
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_READ = 2'b01,
        ST_CALC = 2'b10
    } tor_seq_t;
    tor_seq_t st_reg;
    logic [1:0] ph_reg;
    logic [31:0] theta_rd, theta_wr;
    logic ram_we;
    logic [1:0] ram_waddr;
    logic [31:0] theta_max_reg, theta_acc_reg;
    logic clr_replica;
    assign clr_replica = mem_reset || blocked || param_wr || mode_off;

    function automatic logic [15:0] phase_sel(input tor_pkg::tor_phase_t p, input logic [1:0] n);
        case (n)
            2'd0: phase_sel = p.ia;
            2'd1: phase_sel = p.ib;
            default: phase_sel = p.ic;
        endcase
    endfunction : phase_sel

    // one euler step: theta += (i^2*kinv + amb - theta) / tau_eff
    logic [31:0] i_ph;
    logic [63:0] i_sq, tau_eff64;
    logic signed [63:0] drive, delta;
    always_comb begin
        i_ph = {16'h0, phase_sel(ph_s2, ph_reg)};
        i_sq = (64'(i_ph) * 64'(i_ph) * 64'(kinv_reg)) >> 16;
        tau_eff64 = standstill ? ((64'(tau_reg) * 64'(kstop_reg)) >> `TOR_KSTOP_FRAC)
            : 64'(tau_reg);
        if (tau_eff64 == 64'h0) begin
            tau_eff64 = 64'h1;
        end
        drive = $signed(i_sq) + 64'(amb_term) - $signed({32'h0, theta_rd});
        delta = drive / $signed(tau_eff64);
        theta_wr = theta_rd;
        if (!frozen) begin
            if ($signed(64'(theta_rd)) + delta < 0) begin
                theta_wr = 32'h0;
            end else begin
                theta_wr = 32'($signed({32'h0, theta_rd}) + delta);
            end
        end
        ram_we = clr_replica || (st_reg == ST_CALC);
        ram_waddr = clr_replica ? 2'd0 : ph_reg;
        if (clr_replica) begin
            theta_wr = 32'h0;
        end
    end

    // a one-cycle clear still wipes all three words, one per cycle
    logic [1:0] clr_left;
    logic clr_now;
    assign clr_now = clr_replica || !aresetn || (clr_left != 2'd0);
    always_ff @(posedge aclk) begin
        if (!aresetn || clr_replica) begin
            clr_left <= 2'd2;
        end else if (clr_left != 2'd0) begin
            clr_left <= clr_left - 2'd1;
        end
    end

    tor_phase_ram #(.WIDTH(32)) u_ram (
        .aclk(aclk),
        .we(ram_we || clr_now),
        .waddr(clr_now ? ((clr_replica || !aresetn) ? 2'd0 : 2'd3 - clr_left) : ram_waddr),
        .wdata(clr_now ? 32'h0 : theta_wr),
        .raddr(ph_reg),
        .rdata(theta_rd)
    );

    always_ff @(posedge aclk) begin
        if (clr_now) begin
            st_reg <= ST_IDLE;
            ph_reg <= 2'd0;
            theta_acc_reg <= 32'h0;
            theta_max_reg <= 32'h0;
        end else begin
            case (st_reg)
                ST_IDLE: begin
                    if (tick) begin
                        st_reg <= ST_READ;
                        ph_reg <= 2'd0;
                        theta_acc_reg <= 32'h0;
                    end
                end
                ST_READ: st_reg <= ST_CALC;
                ST_CALC: begin
                    if (theta_wr > theta_acc_reg) begin
                        theta_acc_reg <= theta_wr;
                    end
                    if (ph_reg == 2'd2) begin
                        theta_max_reg <= (theta_wr > theta_acc_reg) ? theta_wr : theta_acc_reg;
                        st_reg <= ST_IDLE;
                    end else begin
                        ph_reg <= ph_reg + 2'd1;
                        st_reg <= ST_READ;
                    end
                end
                default: st_reg <= ST_IDLE;
            endcase
        end
    end

    // alarm level as percent of trip level
    logic [31:0] alarm_lvl;
    assign alarm_lvl = 32'((64'(`TOR_THETA_ONE) * 64'(alarm_pct_reg)) / 64'(`TOR_PCT_FULL));

    // emergency run-on timer in ticks
    logic emer_d;
    logic [31:0] emer_cnt;
    logic emer_hold;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            emer_d <= 1'b0;
            emer_cnt <= 32'h0;
        end else begin
            emer_d <= emer_in;
            if (emer_d && !emer_in) begin
                emer_cnt <= t_emer_reg;
            end else if (tick && emer_cnt != 32'h0) begin
                emer_cnt <= emer_cnt - 32'h1;
            end
        end
    end
    assign emer_hold = emer_in || (emer_cnt != 32'h0);

    // messages
    logic trip_state;
    logic trip_next;
    logic active;
    assign active = !blocked && !mode_off;
    assign trip_next = (!active || theta_max_reg < alarm_lvl) ? 1'b0
        : (theta_max_reg >= `TOR_THETA_ONE) || trip_state;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trip_state <= 1'b0;
            msg <= '0;
        end else begin
            trip_state <= trip_next;
            msg.thermal_alarm <= active && (theta_max_reg >= alarm_lvl);
            msg.current_alarm <= active && ({16'h0, i_max} > i_alarm_reg);
            // log follows trip state irrespective of emergency start
            msg.trip_log <= trip_next && (mode_reg == tor_pkg::TOR_MODE_ON);
            msg.trip <= trip_next && (mode_reg == tor_pkg::TOR_MODE_ON)
                && !emer_hold;
            msg.amb_alarm <= amb_err && active;
        end
    end

    // axi read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'b00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'b00;
            case (s_axi_araddr)
                `TOR_OFF_CTRL: s_axi_rdata <= {29'h0, amb_en_reg, mode_reg};
                `TOR_OFF_KINV: s_axi_rdata <= kinv_reg;
                `TOR_OFF_TAU: s_axi_rdata <= tau_reg;
                `TOR_OFF_KSTOP: s_axi_rdata <= kstop_reg;
                `TOR_OFF_ALARM_PCT: s_axi_rdata <= alarm_pct_reg;
                `TOR_OFF_I_ALARM: s_axi_rdata <= i_alarm_reg;
                `TOR_OFF_I_MIN: s_axi_rdata <= i_min_reg;
                `TOR_OFF_I_FREEZE: s_axi_rdata <= i_freeze_reg;
                `TOR_OFF_T_EMER: s_axi_rdata <= t_emer_reg;
                `TOR_OFF_AMB_SCALE: s_axi_rdata <= amb_scale_reg;
                `TOR_OFF_TICK_DIV: s_axi_rdata <= tick_div_reg;
                `TOR_OFF_STATUS: s_axi_rdata <= {24'h0, blocked, emer_hold, frozen,
                    standstill, amb_err, trip_state, msg.current_alarm, msg.thermal_alarm};
                `TOR_OFF_THETA: s_axi_rdata <= theta_max_reg;
                default: begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= 2'b10;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
    assign s_axi_arready = !s_axi_rvalid;
endmodule : tor_top

/* bench/tor_top_assertions.sv */
// port checker for the thermal overload replica top
// assumes it is bound onto tor_top; one clock aclk, reset aresetn active low
`timescale 1ns/1ps

module tor_top_assertions (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // binary inputs and messages
    input wire logic overload_block_in,
    input wire logic emergency_start_in,
    input wire tor_pkg::tor_out_t msg
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_block_silent: assert property (overload_block_in [*6] |-> msg == '0)
        else $error("block input left a message active");
    chk_emer_no_trip: assert property (emergency_start_in [*6] |-> !msg.trip)
        else $error("trip seen during emergency start");
    chk_trip_logged: assert property (msg.trip |-> msg.trip_log)
        else $error("trip without trip log");
    chk_trip_above_alarm: assert property (msg.trip |-> msg.thermal_alarm)
        else $error("trip while replica below alarm level");
    chk_trip_drop_level: assert property ($fell(msg.trip_log) |-> !msg.thermal_alarm)
        else $error("trip dropped while alarm level still reached");
    chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response not held");
    chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    chk_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    chk_busy_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
endmodule : tor_top_assertions

bind tor_top tor_top_assertions u_chk (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .overload_block_in,
    .emergency_start_in, .msg
);

/* bench/tor_meas_src.sv */
// measurement and binary-input source in front of the replica
// assumes bench commands; lines change away from the device's sampling edge
`timescale 1ns/1ps

module tor_meas_src (
    // clock
    input wire logic aclk,
    // commands
    input wire tor_pkg::tor_phase_t cur_cmd,
    input wire logic [15:0] amb_cmd,
    input wire logic amb_ok_cmd,
    input wire logic [2:0] bin_cmd,
    // lines to the device
    output tor_pkg::tor_phase_t phase_rms,
    output logic [15:0] amb_temp,
    output logic amb_valid,
    output logic [2:0] bin_out
);
    initial begin
        phase_rms = '0;
        amb_temp = '0;
        amb_valid = 1'b0;
        bin_out = '0;
    end
    always @(negedge aclk) begin
        phase_rms <= cur_cmd;
        amb_valid <= amb_ok_cmd;
        // a faulted sensor shows a changing pattern, the last reading and its complement in turn
        amb_temp <= amb_ok_cmd ? amb_cmd : ~amb_temp;
        bin_out <= bin_cmd;
    end
endmodule : tor_meas_src

/* bench/thermal_overload_replica_test.sv */
// self-checking bench for the thermal overload replica
// assumes tor_top, tor_meas_src and the checker are compiled first
`timescale 1ns/1ps
`include "tor_map.svh"

module thermal_overload_replica_test;
    localparam int TA = 4;
    localparam int CA = 3;
    localparam int TR = 2;
    localparam int TL = 1;
    localparam int AA = 0;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] awaddr = '0;
    logic [11:0] araddr = '0;
    logic [31:0] wdata = '0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, amb_valid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [15:0] amb = '0;
    logic [15:0] amb_temp;
    logic amb_ok = 1'b1;
    logic [2:0] bin = '0;
    logic [2:0] bin_out;
    tor_pkg::tor_phase_t cur = '0;
    tor_pkg::tor_phase_t phase_rms;
    tor_pkg::tor_out_t msg;
    int num_errors = 0;
    int samples_checked = 0;
    logic [43:0] rst_tab [12] = '{{`TOR_OFF_CTRL, 32'h1}, {`TOR_OFF_KINV, `TOR_RST_KINV},
        {`TOR_OFF_TAU, `TOR_RST_TAU}, {`TOR_OFF_KSTOP, `TOR_RST_KSTOP},
        {`TOR_OFF_ALARM_PCT, `TOR_RST_ALARM_PCT}, {`TOR_OFF_I_ALARM, `TOR_RST_I_ALARM},
        {`TOR_OFF_I_MIN, `TOR_RST_I_MIN}, {`TOR_OFF_I_FREEZE, `TOR_RST_I_FREEZE},
        {`TOR_OFF_T_EMER, `TOR_RST_T_EMER}, {`TOR_OFF_TICK_DIV, `TOR_RST_TICK_DIV},
        {`TOR_OFF_STATUS, 32'h1 << `TOR_ST_STANDSTILL}, {`TOR_OFF_THETA, 32'h0}};

    always #2 aclk = ~aclk;

    tor_meas_src src (.aclk(aclk), .cur_cmd(cur), .amb_cmd(amb), .amb_ok_cmd(amb_ok),
        .bin_cmd(bin), .phase_rms(phase_rms), .amb_temp(amb_temp),
        .amb_valid(amb_valid), .bin_out(bin_out));

    tor_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .phase_rms(phase_rms), .amb_temp(amb_temp),
        .amb_valid(amb_valid), .thermal_memory_reset_in(bin_out[0]),
        .overload_block_in(bin_out[1]), .emergency_start_in(bin_out[2]), .msg(msg));

    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        cmp("bresp", 32'(er), 32'(bresp));
        @(posedge aclk);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [1:0] er, output logic [31:0] d);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        rready <= 1'b0;
        cmp("rresp", 32'(er), 32'(rresp));
        @(posedge aclk);
    endtask : rd

    task automatic wt(input string nm, input int b, input logic v, input int lim);
        int n;
        n = 0;
        while (msg[b] !== v && n < lim) begin
            @(posedge aclk);
            n++;
        end
        cmp(nm, 32'(v), 32'(msg[b]));
    endtask : wt

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_sim

    initial begin
        repeat (20000) @(posedge aclk);
        num_errors++;
        end_sim();
    end

    initial begin
        logic [31:0] d;
        int p;
        logic [15:0] lvl;
        p = $urandom(8867);
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        foreach (rst_tab[i]) begin
            rd(rst_tab[i][43:32], 2'b00, d);
            cmp("reset value", rst_tab[i][31:0], d);
        end
        rd(12'h100, 2'b10, d);
        cmp("unmapped data", 32'h0, d);
        wr(`TOR_OFF_STATUS, 32'h1, 2'b10);
        $display("test registers done");
        wr(`TOR_OFF_TICK_DIV, 32'h3, 2'b00);
        wr(`TOR_OFF_TAU, 32'h4, 2'b00);
        wr(`TOR_OFF_KSTOP, 32'h100, 2'b00);
        wr(`TOR_OFF_T_EMER, 32'ha, 2'b00);
        wr(`TOR_OFF_I_ALARM, 32'h3000, 2'b00);
        p = $urandom % 3;
        lvl = 16'h2000 + 16'($urandom % 2048);
        cur <= tor_pkg::tor_phase_t'(48'(lvl) << (16 * p));
        wt("thermal alarm", TA, 1'b1, 200);
        wt("trip", TR, 1'b1, 200);
        cmp("current alarm low", 32'h0, 32'(msg[CA]));
        cur.ib <= 16'h3001;
        wt("current alarm", CA, 1'b1, 20);
        $display("test trip done");
        bin[2] <= 1'b1;
        wt("trip masked", TR, 1'b0, 10);
        cmp("trip log kept", 32'h1, 32'(msg[TL]));
        rd(`TOR_OFF_THETA, 2'b00, d);
        cmp("replica kept", 32'h1, 32'(d >= `TOR_THETA_ONE));
        bin[2] <= 1'b0;
        repeat (20) @(posedge aclk);
        cmp("trip run-on", 32'h0, 32'(msg[TR]));
        wt("trip after run-on", TR, 1'b1, 80);
        $display("test emergency done");
        wr(`TOR_OFF_I_FREEZE, 32'h1000, 2'b00);
        rd(`TOR_OFF_THETA, 2'b00, d);
        cmp("replica cleared", 32'h0, d);
        repeat (40) @(posedge aclk);
        rd(`TOR_OFF_THETA, 2'b00, d);
        cmp("replica frozen", 32'h0, d);
        rd(`TOR_OFF_STATUS, 2'b00, d);
        cmp("frozen flag", 32'h1, 32'(d[`TOR_ST_FROZEN]));
        wt("trip dropped", TR, 1'b0, 20);
        wr(`TOR_OFF_I_FREEZE, 32'hffff, 2'b00);
        wt("trip again", TR, 1'b1, 200);
        repeat (40) @(posedge aclk);
        cur <= '0;
        repeat (8) @(posedge aclk);
        cmp("trip held", 32'h1, 32'(msg[TR]));
        rd(`TOR_OFF_STATUS, 2'b00, d);
        cmp("standstill", 32'h1, 32'(d[`TOR_ST_STANDSTILL]));
        bin[0] <= 1'b1;
        repeat (8) @(posedge aclk);
        rd(`TOR_OFF_THETA, 2'b00, d);
        cmp("memory reset", 32'h0, d);
        wt("trip after reset", TR, 1'b0, 10);
        bin[0] <= 1'b0;
        $display("test freeze and reset done");
        cur <= tor_pkg::tor_phase_t'(48'(lvl) << (16 * p));
        @(posedge aclk);
        cur.ic <= 16'h3001;
        wt("current alarm", CA, 1'b1, 20);
        bin[1] <= 1'b1;
        repeat (8) @(posedge aclk);
        cmp("blocked messages", 32'h0, 32'(msg));
        rd(`TOR_OFF_THETA, 2'b00, d);
        cmp("blocked replica", 32'h0, d);
        bin[1] <= 1'b0;
        wr(`TOR_OFF_CTRL, 32'h2, 2'b00);
        wt("alarm only", TA, 1'b1, 200);
        repeat (40) @(posedge aclk);
        cmp("no trip", 32'h0, 32'(msg[TR]));
        cmp("no trip log", 32'h0, 32'(msg[TL]));
        amb_ok <= 1'b0;
        wr(`TOR_OFF_CTRL, 32'h6, 2'b00);
        wt("ambient alarm", AA, 1'b1, 50);
        amb <= 16'h0028;
        amb_ok <= 1'b1;
        wt("ambient good", AA, 1'b0, 50);
        $display("test block and modes done");
        end_sim();
    end
endmodule : thermal_overload_replica_test
